// File: rtl/irq_flag_bank.sv
`timescale 1ns/1ps
// interrupt request flag bank, three bytes
module irq_flag_bank (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // cpu access
    input wire irq_flag_pkg::cpu_req_type cpu_req,
    output logic [15:0] rdata,
    output logic stall,
    // one-cycle request pulses from sources, indexed by flag bit
    input wire logic [23:0] source_req,
    // one-cycle acknowledge from cpu, indexed by flag bit
    input wire logic [23:0] ack,
    // pending flags toward priority logic
    output logic [23:0] flags
);
    logic [23:0] flags_ff; // the flag bits
    logic [15:0] rdata_ff; // registered read data
    logic stall_ff; // registered stall
    logic [23:0] wr_en; // bits touched by this write
    logic [23:0] wr_val; // value written to touched bits
    logic hit0; // access covers byte0 lane
    logic hit1; // access covers byte1 lane
    logic hit2; // access covers byte2 lane
    logic [7:0] lane_lo; // data for lower address byte
    logic [7:0] lane_hi; // data for upper address byte
    logic word_acc; // 16-bit access
    logic [7:0] bitmask; // one-hot bit select
    logic stall_busy; // counter owes more than one clock
    logic wr_any; // a flag write landed

    assign word_acc = (cpu_req.size == irq_flag_pkg::size_word);
    assign bitmask = 8'h01 << cpu_req.bit_sel;
    assign lane_lo = cpu_req.wdata[7:0];
    assign lane_hi = cpu_req.wdata[15:8];

    // address decode; word access pairs low byte at lower address
    always_comb begin
        hit0 = (cpu_req.addr == irq_flag_pkg::addr_byte0);
        hit1 = (cpu_req.addr == irq_flag_pkg::addr_byte1)
            || (word_acc && hit0); // RL5
        hit2 = (cpu_req.addr == irq_flag_pkg::addr_byte2);
    end

    // build per-bit write enable and value
    always_comb begin
        wr_en = 24'h0;
        wr_val = 24'h0;
        if (cpu_req.write) begin
            unique case (cpu_req.size)
                irq_flag_pkg::size_bit: begin // RL4
                    if (hit0) begin
                        wr_en[7:0] = bitmask;
                        wr_val[7:0] = {8{lane_lo[0]}};
                    end
                    if (cpu_req.addr == irq_flag_pkg::addr_byte1) begin
                        wr_en[15:8] = bitmask;
                        wr_val[15:8] = {8{lane_lo[0]}};
                    end
                    if (hit2) begin
                        wr_en[23:16] = bitmask;
                        wr_val[23:16] = {8{lane_lo[0]}};
                    end
                end
                irq_flag_pkg::size_byte: begin // RL4
                    if (hit0) begin
                        wr_en[7:0] = 8'hff;
                        wr_val[7:0] = lane_lo;
                    end
                    if (cpu_req.addr == irq_flag_pkg::addr_byte1) begin
                        wr_en[15:8] = 8'hff;
                        wr_val[15:8] = lane_lo;
                    end
                    if (hit2) begin
                        wr_en[23:16] = 8'hff;
                        wr_val[23:16] = lane_lo;
                    end
                end
                irq_flag_pkg::size_word: begin // RL5
                    if (hit0) begin
                        wr_en[15:0] = 16'hffff;
                        wr_val[15:0] = {lane_hi, lane_lo};
                    end
                    if (hit2) begin
                        // upper partner byte is outside this bank
                        wr_en[23:16] = 8'hff;
                        wr_val[23:16] = lane_lo;
                    end
                end
                default: begin
                    wr_en = 24'h0;
                    wr_val = 24'h0;
                end
            endcase
        end
        // fixed-zero bit is never written
        wr_en[23] = 1'b0; // RL11
    end

    // any write to a flag byte stalls, even one that only hits bit 7
    assign wr_any = cpu_req.write && (hit0 || hit1 || hit2); // RL7

    // per-bit flag update, one generate loop
    // priority: reset, fixed bit 23, then source set, then ack, then software value
    // a source pulse beats a same-cycle clear so no event is lost
    generate
        for (genvar i = 0; i < irq_flag_pkg::num_flags; i++) begin : g_flag
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    flags_ff[i] <= 1'b0; // RL6
                end else if (i == 23) begin
                    flags_ff[i] <= 1'b0; // RL11
                end else if (source_req[i]) begin
                    flags_ff[i] <= 1'b1; // RL1 RL12
                end else if (ack[i]) begin
                    flags_ff[i] <= 1'b0; // RL2 RL3
                end else if (wr_en[i]) begin
                    flags_ff[i] <= wr_val[i]; // RL1 RL2
                end
            end
        end
    endgenerate

    // registered read mux, unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rdata_ff <= 16'h0;
        end else if (cpu_req.read) begin
            if (word_acc && hit0) begin
                rdata_ff <= flags_ff[15:0]; // RL5
            end else if (word_acc && hit2) begin
                rdata_ff <= {8'h00,
                    flags_ff[23:16] & irq_flag_pkg::byte2_mask}; // RL11
            end else if (hit0) begin
                rdata_ff <= {8'h00, flags_ff[7:0]}; // RL4
            end else if (cpu_req.addr == irq_flag_pkg::addr_byte1) begin
                rdata_ff <= {8'h00, flags_ff[15:8]};
            end else if (hit2) begin
                rdata_ff <= {8'h00,
                    flags_ff[23:16] & irq_flag_pkg::byte2_mask}; // RL11
            end else begin
                rdata_ff <= 16'h0;
            end
        end
    end

    // extra clocks on flag writes
    irq_write_stall u_stall (
        .clock(clock),
        .resetn(resetn),
        .start(wr_any),
        .busy(stall_busy)
    );

    // stall output registered from the write decode and the counter state
    always_ff @(posedge clock) begin
        if (!resetn) begin
            stall_ff <= 1'b0;
        end else begin
            // write cycle gives the first clock, the counter the second
            stall_ff <= wr_any | stall_busy; // RL7
        end
    end

    assign flags = flags_ff; // RL8
    assign rdata = rdata_ff;
    assign stall = stall_ff;

    // assertions
    localparam int pos_i2c_l = irq_flag_pkg::pos_i2c; // watched ack bit
    localparam int pos_timer1_l = irq_flag_pkg::pos_timer1; // collision bit
    property p_src_sets;
        @(posedge clock) disable iff (!resetn)
        source_req[0] |=> flags_ff[0];
    endproperty
    a_src_sets: assert property (p_src_sets) // RL1
        else $error("source request did not set flag");

    property p_ack_clears;
        @(posedge clock) disable iff (!resetn)
        (ack[pos_i2c_l] && !source_req[pos_i2c_l]) |=> !flags_ff[pos_i2c_l];
    endproperty
    a_ack_clears: assert property (p_ack_clears) // RL3
        else $error("acknowledge did not clear flag");

    property p_set_wins;
        @(posedge clock) disable iff (!resetn)
        (source_req[pos_timer1_l] && wr_en[pos_timer1_l]
            && !wr_val[pos_timer1_l]) |=> flags_ff[pos_timer1_l];
    endproperty
    a_set_wins: assert property (p_set_wins) // RL12
        else $error("software clear lost a request");

    property p_sw_clear;
        @(posedge clock) disable iff (!resetn)
        (wr_en[2] && !wr_val[2] && !source_req[2]) |=> !flags_ff[2];
    endproperty
    a_sw_clear: assert property (p_sw_clear) // RL2
        else $error("software zero did not clear flag");

    property p_bit7_zero;
        @(posedge clock) disable iff (!resetn)
        1'b1 |=> !flags_ff[23];
    endproperty
    a_bit7_zero: assert property (p_bit7_zero) // RL11
        else $error("fixed bit of byte2 became set");

    property p_reset_zero;
        @(posedge clock) !resetn |=> (flags_ff == 24'h0);
    endproperty
    a_reset_zero: assert property (p_reset_zero) // RL6
        else $error("flags not zero after reset");

    property p_stall_two;
        @(posedge clock) disable iff (!resetn)
        (wr_any && !$past(stall_busy)) |=> stall ##1 stall;
    endproperty
    a_stall_two: assert property (p_stall_two) // RL7
        else $error("flag write did not stall two clocks");

    property p_word_read;
        @(posedge clock) disable iff (!resetn)
        (cpu_req.read && word_acc && hit0)
            |=> (rdata == $past(flags_ff[15:0]));
    endproperty
    a_word_read: assert property (p_word_read) // RL5
        else $error("word read did not pair byte0 and byte1");

    // a written one raises the flag unless an ack takes it that cycle
    property p_write_sets;
        @(posedge clock) disable iff (!resetn)
        (wr_en[2] && wr_val[2] && !ack[2]) |=> flags_ff[2];
    endproperty
    a_write_sets: assert property (p_write_sets) // RL1
        else $error("software one did not set flag");

    // a bit write at byte1 touches the selected bit only
    property p_bit_write;
        @(posedge clock) disable iff (!resetn)
        (cpu_req.write && cpu_req.size == irq_flag_pkg::size_bit
            && cpu_req.addr == irq_flag_pkg::addr_byte1
            && source_req[15:8] == 8'h00 && ack[15:8] == 8'h00)
            |=> flags_ff[15:8] == (($past(flags_ff[15:8])
            & ~(8'h01 << $past(cpu_req.bit_sel)))
            | ({7'h00, $past(cpu_req.wdata[0])} << $past(cpu_req.bit_sel)));
    endproperty
    a_bit_write: assert property (p_bit_write) // RL4
        else $error("bit write did not land on its bit");

    // a whole-byte write at byte0 lands as written
    property p_byte_write;
        @(posedge clock) disable iff (!resetn)
        (cpu_req.write && cpu_req.size == irq_flag_pkg::size_byte
            && cpu_req.addr == irq_flag_pkg::addr_byte0
            && source_req[7:0] == 8'h00 && ack[7:0] == 8'h00)
            |=> flags_ff[7:0] == $past(cpu_req.wdata[7:0]);
    endproperty
    a_byte_write: assert property (p_byte_write) // RL4
        else $error("byte write did not land");

    // a word write at byte0 fills byte0 from low data, byte1 from high
    property p_word_write;
        @(posedge clock) disable iff (!resetn)
        (cpu_req.write && cpu_req.size == irq_flag_pkg::size_word
            && cpu_req.addr == irq_flag_pkg::addr_byte0
            && source_req[15:0] == 16'h0000 && ack[15:0] == 16'h0000)
            |=> flags_ff[15:0] == $past(cpu_req.wdata);
    endproperty
    a_word_write: assert property (p_word_write) // RL5
        else $error("word write did not pair byte0 and byte1");

    // a word write at byte2 lands its low byte, the upper half is dropped
    property p_byte2_word;
        @(posedge clock) disable iff (!resetn)
        (cpu_req.write && cpu_req.size == irq_flag_pkg::size_word
            && cpu_req.addr == irq_flag_pkg::addr_byte2
            && source_req[22:16] == 7'h00 && ack[22:16] == 7'h00)
            |=> flags_ff[22:16] == $past(cpu_req.wdata[6:0]);
    endproperty
    a_byte2_word: assert property (p_byte2_word) // RL5
        else $error("word write at byte2 did not land");

    // the fixed bit of byte2 always reads back as zero
    property p_rdata_mask;
        @(posedge clock) disable iff (!resetn)
        (cpu_req.read && cpu_req.addr == irq_flag_pkg::addr_byte2)
            |=> !rdata[7];
    endproperty
    a_rdata_mask: assert property (p_rdata_mask) // RL11
        else $error("fixed bit of byte2 read as one");

    // stall falls after exactly two clocks when no new write follows
    property p_stall_ends;
        @(posedge clock) disable iff (!resetn)
        (wr_any ##1 !wr_any ##1 !wr_any) |=> !stall;
    endproperty
    a_stall_ends: assert property (p_stall_ends) // RL7
        else $error("stall lasted beyond two clocks");

    // with no source, ack or write the flags keep their value
    property p_flag_hold;
        @(posedge clock) disable iff (!resetn)
        (source_req == 24'h0 && ack == 24'h0 && !cpu_req.write)
            |=> $stable(flags_ff);
    endproperty
    a_flag_hold: assert property (p_flag_hold) // RL2
        else $error("flags changed with no cause");

    // every flag that can pend: a source sets it, a lone ack clears it
    generate
        for (genvar j = 0; j < irq_flag_pkg::num_flags - 1; j++) begin : g_chk
            property p_src_each;
                @(posedge clock) disable iff (!resetn)
                source_req[j] |=> flags_ff[j];
            endproperty
            a_src_each: assert property (p_src_each) // RL1
                else $error("source request did not set its flag");

            property p_ack_each;
                @(posedge clock) disable iff (!resetn)
                (ack[j] && !source_req[j]) |=> !flags_ff[j];
            endproperty
            a_ack_each: assert property (p_ack_each) // RL3
                else $error("acknowledge did not clear its flag");
        end
    endgenerate
endmodule : irq_flag_bank

// File: rtl/irq_flag_pkg.sv
// Overview of operation
// RL1 - source request or written 1 sets flag
// RL2 - acknowledge, reset or written 0 clears flag
// RL3 - acknowledge clears flag before service entry
// RL4 - single-bit and whole-byte access supported
// RL5 - byte pairs accessible as one 16-bit word
// RL6 - reset loads every flag register with zero
// RL7 - flag writes add two execution clocks
// RL8 - flag 1 means pending, 0 means none
// RL9 - byte0: watchdog, voltage, pins 0-3, dma 0-1
// RL10 - byte1: timers 1/0, i2c, rx error, serial
// RL11 - byte2: timers 2/3, adc..flash, bit7 zero
// RL12 - request beats simultaneous software clear
package irq_flag_pkg;
    // register byte addresses
    localparam logic [19:0] addr_byte0 = 20'hfffe0;
    localparam logic [19:0] addr_byte1 = 20'hfffe1;
    localparam logic [19:0] addr_byte2 = 20'hfffe2;
    localparam logic [19:0] addr_byte3 = 20'hfffe3;
    // reset value of every flag byte
    localparam logic [7:0] flag_reset = 8'h00;
    // bit 7 of byte2 is fixed at zero
    localparam logic [7:0] byte2_mask = 8'h7f;
    // extra wait clocks on a flag write
    localparam logic [1:0] write_stall_clocks = 2'h2;
    localparam int num_flags = 24;
    // bit positions byte0
    localparam int pos_watchdog = 0; // RL9
    localparam int pos_voltage = 1;
    localparam int pos_pin0 = 2;
    localparam int pos_dma0 = 6;
    localparam int pos_dma1 = 7;
    // bit positions byte1
    localparam int pos_serial_tx = 8; // RL10
    localparam int pos_serial_rx = 9;
    localparam int pos_rx_error = 10;
    localparam int pos_i2c = 13;
    localparam int pos_timer0 = 14;
    localparam int pos_timer1 = 15;
    // bit positions byte2
    localparam int pos_timer2 = 16;
    localparam int pos_timer3 = 17;
    localparam int pos_flash = 22;
    // access size encoding
    typedef enum logic [1:0] {
        size_bit = 2'b00,
        size_byte = 2'b01,
        size_word = 2'b10
    } access_size_type;
    // cpu access request bundle
    typedef struct packed {
        logic read;
        logic write;
        access_size_type size;
        logic [2:0] bit_sel;
        logic [19:0] addr;
        logic [15:0] wdata;
    } cpu_req_type;
endpackage : irq_flag_pkg

// File: rtl/irq_write_stall.sv
`timescale 1ns/1ps
// counts the extra execution clocks of a flag write
module irq_write_stall (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // trigger from decoded flag write
    input wire logic start,
    // stall towards the cpu pipeline
    output logic busy
);
    logic [1:0] count_ff; // clocks still owed
    // load on write, count down to zero
    always_ff @(posedge clock) begin
        if (!resetn) begin
            count_ff <= 2'h0;
        end else if (start) begin
            count_ff <= irq_flag_pkg::write_stall_clocks; // RL7
        end else if (count_ff != 2'h0) begin
            count_ff <= count_ff - 2'h1;
        end
    end
    // high while more than the last owed clock remains; the bank
    // registers this, so its stall output still comes from a flop
    assign busy = (count_ff > 2'h1);
endmodule : irq_write_stall

// File: tb/irq_partner_model.sv
`timescale 1ns/1ps
// peripheral sources and the cpu acknowledge path, far side of the bank
module irq_partner_model (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // commands from the bench
    input wire logic [23:0] src_cmd,
    input wire logic [23:0] ack_cmd,
    // pending flags as the cpu sees them
    input wire logic [23:0] flags,
    // pulses toward the bank
    output logic [23:0] source_req,
    output logic [23:0] ack
);
    // one-cycle pulses; the cpu only acknowledges what is pending
    always_ff @(posedge clock) begin
        if (!resetn) begin
            source_req <= 24'h000000;
            ack <= 24'h000000;
        end else begin
            source_req <= src_cmd;
            ack <= ack_cmd & flags;
        end
    end
endmodule : irq_partner_model

// File: tb/tb_interrupt_request_flag_bank.sv
`timescale 1ns/1ps
// bench for the flag bank: bus tasks and sequences of calls
module tb_interrupt_request_flag_bank;
    logic clock;
    logic resetn;
    irq_flag_pkg::cpu_req_type cpu_req;
    logic [15:0] rdata;
    logic stall;
    logic [23:0] source_req, ack, flags;
    logic [23:0] src_cmd, ack_cmd; // partner commands
    int num_errors, n_checks, cycles;

    irq_flag_bank irq_flag_bank_inst (.clock(clock), .resetn(resetn),
        .cpu_req(cpu_req), .rdata(rdata), .stall(stall),
        .source_req(source_req), .ack(ack), .flags(flags));
    irq_partner_model irq_partner_model_inst (.clock(clock),
        .resetn(resetn), .src_cmd(src_cmd), .ack_cmd(ack_cmd),
        .flags(flags), .source_req(source_req), .ack(ack));

    // free running clock, 10 ns
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // hang guard, far above the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end

    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // compare a vector result
    task automatic check_vec(input logic [23:0] got, input logic [23:0] w);
        n_checks++;
        if (got !== w) begin
            num_errors++;
            $display("Error at %0t: value %h expected %h", $time, got, w);
        end
    endtask : check_vec

    // compare a single flag
    task automatic check_bit(input logic got, input logic w);
        n_checks++;
        if (got !== w) begin
            num_errors++;
            $display("Error at %0t: stall %b expected %b", $time, got, w);
        end
    endtask : check_bit

    // one request cycle, driven just after the edge
    task automatic access(input logic rd, input logic [1:0] sz,
        input logic [19:0] a, input logic [2:0] b, input logic [15:0] d);
        cpu_req.read = rd;
        cpu_req.write = !rd;
        cpu_req.size = irq_flag_pkg::access_size_type'(sz);
        cpu_req.bit_sel = b;
        cpu_req.addr = a;
        cpu_req.wdata = d;
        @(posedge clock);
        #1;
        cpu_req.read = 1'b0;
        cpu_req.write = 1'b0;
    endtask : access

    // write, then watch the two stall clocks run out
    task automatic wr(input logic [1:0] sz, input logic [19:0] a,
        input logic [2:0] b, input logic [15:0] d);
        access(1'b0, sz, a, b, d);
        check_bit(stall, 1'b1);
        @(posedge clock);
        #1;
        check_bit(stall, 1'b1);
        @(posedge clock);
        #1;
        check_bit(stall, 1'b0);
    endtask : wr

    // read and compare, data valid one cycle later
    task automatic rd(input logic [1:0] sz, input logic [19:0] a,
        input logic [23:0] w);
        access(1'b1, sz, a, 3'h0, 16'h0000);
        check_vec({8'h00, rdata}, w);
        // idle edge, so read is never lowered and raised in one step
        @(posedge clock);
        #1;
    endtask : rd

    // main sequence
    initial begin
        resetn = 1'b0;
        cpu_req = '0;
        src_cmd = 24'h000000;
        ack_cmd = 24'h000000;
        num_errors = 0;
        n_checks = 0;
        cycles = 0;
        repeat (20) @(posedge clock);
        #1;
        resetn = 1'b1;
        check_vec(flags, 24'h000000);
        for (int i = 0; i < 3; i++) begin
            rd(2'h1, irq_flag_pkg::addr_byte0 + 20'(i), 24'h000000);
        end
        $display("reset values done");
        wr(2'h1, irq_flag_pkg::addr_byte0, 3'h0, 16'h00ff);
        rd(2'h1, irq_flag_pkg::addr_byte0, 24'h0000ff);
        wr(2'h1, irq_flag_pkg::addr_byte0, 3'h0, 16'h0000);
        check_vec(flags, 24'h000000);
        wr(2'h0, irq_flag_pkg::addr_byte1, 3'h5, 16'h0001);
        check_vec(flags, 24'h1 << irq_flag_pkg::pos_i2c);
        wr(2'h0, irq_flag_pkg::addr_byte1, 3'h5, 16'h0000);
        check_vec(flags, 24'h000000);
        wr(2'h2, irq_flag_pkg::addr_byte0, 3'h0, 16'ha55a);
        rd(2'h2, irq_flag_pkg::addr_byte0, 24'h00a55a);
        rd(2'h1, irq_flag_pkg::addr_byte1, 24'h0000a5);
        wr(2'h1, irq_flag_pkg::addr_byte2, 3'h0, 16'h00ff);
        rd(2'h1, irq_flag_pkg::addr_byte2, 24'h00007f);
        wr(2'h0, irq_flag_pkg::addr_byte2, 3'h7, 16'h0001);
        check_vec(flags, 24'h7fa55a);
        wr(2'h2, irq_flag_pkg::addr_byte2, 3'h0, 16'h1203);
        check_vec(flags, 24'h03a55a);
        rd(2'h2, irq_flag_pkg::addr_byte2, 24'h000003);
        rd(2'h1, irq_flag_pkg::addr_byte3, 24'h000000);
        $display("software access done");
        // second reset in mid-run with flags pending
        resetn = 1'b0;
        @(posedge clock);
        #1;
        resetn = 1'b1;
        check_vec(flags, 24'h000000);
        // every source but bit 23 sets its own bit, acknowledge clears it
        for (int i = 0; i < 24; i++) begin
            src_cmd = 24'h1 << i;
            @(posedge clock);
            #1;
            src_cmd = 24'h000000;
            @(posedge clock);
            #1;
            check_vec(flags, (i == 23) ? 24'h0 : 24'h1 << i);
            ack_cmd = 24'h1 << i;
            @(posedge clock);
            #1;
            ack_cmd = 24'h000000;
            @(posedge clock);
            #1;
            check_vec(flags, 24'h000000);
        end
        $display("sources and acknowledge done");
        // request lands in the same cycle as a software clear
        src_cmd = 24'h1 << irq_flag_pkg::pos_timer1;
        @(posedge clock);
        #1;
        src_cmd = 24'h000000;
        wr(2'h1, irq_flag_pkg::addr_byte1, 3'h0, 16'h0000);
        check_vec(flags, 24'h1 << irq_flag_pkg::pos_timer1);
        $display("collision done");
        end_of_test();
    end
endmodule : tb_interrupt_request_flag_bank
